// ==== src/ref_monitor_consts.svh ====
// register offsets, field positions and reset values for the profile bank
`ifndef REF_MONITOR_CONSTS_SVH
`define REF_MONITOR_CONSTS_SVH

`define ADDR_INPUT_PROFILE_SELECT 7'h65
`define ADDR_PROFILE_A_FREQ_MULT_LO 7'h67
`define ADDR_PROFILE_A_FREQ_MULT_HI 7'h68
`define ADDR_PROFILE_A_PERIOD_LOW_BOUND 7'h69
`define ADDR_PROFILE_A_PERIOD_HIGH_BOUND 7'h6A
`define ADDR_PROFILE_A_FREQ_LOW_BOUND_LO 7'h6B
`define ADDR_PROFILE_A_FREQ_LOW_BOUND_HI 7'h6C
`define ADDR_PROFILE_A_FREQ_HIGH_BOUND_LO 7'h6D
`define ADDR_PROFILE_A_FREQ_HIGH_BOUND_HI 7'h6E
`define ADDR_PROFILE_A_WINDOW_CYCLES 7'h6F
`define ADDR_PROFILE_A_PRESCALE 7'h70
`define ADDR_PROFILE_B_FREQ_MULT_LO 7'h71
`define ADDR_PROFILE_B_FREQ_MULT_HI 7'h72
`define ADDR_PROFILE_B_PERIOD_LOW_BOUND 7'h73
`define ADDR_PROFILE_B_PERIOD_HIGH_BOUND 7'h74
`define ADDR_PROFILE_B_FREQ_LOW_BOUND_LO 7'h75
`define ADDR_PROFILE_B_FREQ_LOW_BOUND_HI 7'h76
`define ADDR_PROFILE_B_FREQ_HIGH_BOUND_LO 7'h77
`define ADDR_PROFILE_B_FREQ_HIGH_BOUND_HI 7'h78
`define ADDR_PROFILE_B_WINDOW_CYCLES 7'h79
`define ADDR_PROFILE_B_PRESCALE 7'h7A

`define REG_RESET 8'h00
`define MULT_HI_MSB 5
`define PRESCALE_BIT 0
`define SELECT_FIELD_MSB 5
`define PRESCALE_RATIO 4

`endif

// ==== src/ref_monitor_pkg.sv ====
// types shared by the custom reference profile bank
package ref_monitor_pkg;

  // per-input profile selection, codes follow declaration order 0..3
  typedef enum logic [1:0] {
    SEL_AUTO,
    SEL_PROFILE_A,
    SEL_PROFILE_B,
    SEL_RESERVED
  } profile_sel_t;

  typedef struct packed {
    logic [13:0] freqMult;
    logic [7:0] periodLow;
    logic [7:0] periodHigh;
    logic [15:0] freqLow;
    logic [15:0] freqHigh;
    logic [7:0] windowCycles;
    logic prescale;
  } profile_t;

endpackage : ref_monitor_pkg

// ==== src/custom_ref_monitor_config.sv ====
// custom reference profile register bank and limit checks
// Functional notes
// - profile A period low bound, bits 7:0, reset zero
// - profile A period high bound in bits 7:0
// - profile A 16-bit frequency low bound, two bytes
// - profile A 16-bit frequency high bound, two bytes
// - window cycle field holds count minus one
// - prescale bit divides reference by four
// - profile B 14-bit multiple of 8 kHz
// - profile B period low bound, reset zero
// - profile B period high bound in bits 7:0
// - 2-bit mode per input: auto, A, B, reserved
// - profile A 14-bit multiple of 8 kHz
`timescale 1ns/1ps
`include "ref_monitor_consts.svh"

module custom_ref_monitor_config
  import ref_monitor_pkg::*;
(
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [6:0] regAddr, // register address from serial port
  input wire logic [7:0] regWrData, // write data
  input wire logic regWr, // write strobe, one cycle
  input wire logic regRd, // read strobe, one cycle
  output logic [7:0] regRdData, // read data, valid cycle after regRd
  input wire logic [2:0] periodValid, // single-cycle result strobe per input
  input wire logic [2:0][7:0] periodMeas, // single-cycle measured count
  input wire logic [2:0] freqValid, // frequency result strobe per input
  input wire logic [2:0][15:0] freqMeas, // frequency measured count
  output logic [2:0][1:0] inputProfileSelect, // mode per input
  output logic [2:0] cfmPrescale, // divide reference by four
  output logic [2:0][8:0] cfmWindowLen, // reference cycles per window
  output logic [2:0][13:0] nominalMult, // nominal freq, 8 kHz units
  output logic [2:0] periodFail, // single-cycle limit violated
  output logic [2:0] freqFail // frequency limit violated
);

  profile_t profA;
  profile_t profB;
  profile_t next_profA;
  profile_t next_profB;
  logic [5:0] selField;
  logic [5:0] next_selField;
  logic [7:0] next_regRdData;
  logic [2:0] next_periodFail;
  logic [2:0] next_freqFail;
  logic [2:0][1:0] next_inputProfileSelect;
  logic [2:0] next_cfmPrescale;
  logic [2:0][8:0] next_cfmWindowLen;
  logic [2:0][13:0] next_nominalMult;

  // true when a count lies outside the inclusive bounds
  function automatic logic outOfRange(input logic [15:0] value,
                                      input logic [15:0] low,
                                      input logic [15:0] high);
    outOfRange = (value < low) || (value > high);
  endfunction : outOfRange

  // picks the profile bound set for one input; auto and reserved give profile B
  function automatic profile_t pickProfile(input logic [1:0] sel,
                                           input profile_t a,
                                           input profile_t b);
    if (sel == SEL_PROFILE_A) begin
      pickProfile = a;
    end else begin
      pickProfile = b;
    end
  endfunction : pickProfile

  // register write decode
  always_comb begin
    next_profA = profA;
    next_profB = profB;
    next_selField = selField;
    if (regWr) begin
      if (regAddr == `ADDR_INPUT_PROFILE_SELECT) begin
        next_selField = regWrData[`SELECT_FIELD_MSB:0];
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_MULT_LO) begin
        next_profA.freqMult[7:0] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_MULT_HI) begin
        next_profA.freqMult[13:8] = regWrData[`MULT_HI_MSB:0];
      end else if (regAddr == `ADDR_PROFILE_A_PERIOD_LOW_BOUND) begin
        next_profA.periodLow = regWrData;
      end else if (regAddr == `ADDR_PROFILE_A_PERIOD_HIGH_BOUND) begin
        next_profA.periodHigh = regWrData;
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_LOW_BOUND_LO) begin
        next_profA.freqLow[7:0] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_LOW_BOUND_HI) begin
        next_profA.freqLow[15:8] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_HIGH_BOUND_LO) begin
        next_profA.freqHigh[7:0] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_HIGH_BOUND_HI) begin
        next_profA.freqHigh[15:8] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_A_WINDOW_CYCLES) begin
        next_profA.windowCycles = regWrData;
      end else if (regAddr == `ADDR_PROFILE_A_PRESCALE) begin
        next_profA.prescale = regWrData[`PRESCALE_BIT];
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_MULT_LO) begin
        next_profB.freqMult[7:0] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_MULT_HI) begin
        next_profB.freqMult[13:8] = regWrData[`MULT_HI_MSB:0];
      end else if (regAddr == `ADDR_PROFILE_B_PERIOD_LOW_BOUND) begin
        next_profB.periodLow = regWrData;
      end else if (regAddr == `ADDR_PROFILE_B_PERIOD_HIGH_BOUND) begin
        next_profB.periodHigh = regWrData;
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_LOW_BOUND_LO) begin
        next_profB.freqLow[7:0] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_LOW_BOUND_HI) begin
        next_profB.freqLow[15:8] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_HIGH_BOUND_LO) begin
        next_profB.freqHigh[7:0] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_HIGH_BOUND_HI) begin
        next_profB.freqHigh[15:8] = regWrData;
      end else if (regAddr == `ADDR_PROFILE_B_WINDOW_CYCLES) begin
        next_profB.windowCycles = regWrData;
      end else if (regAddr == `ADDR_PROFILE_B_PRESCALE) begin
        next_profB.prescale = regWrData[`PRESCALE_BIT];
      end
    end
  end

  // read mux; reserved bits are not stored so they read as zero
  always_comb begin
    next_regRdData = regRdData;
    if (regRd) begin
      if (regAddr == `ADDR_INPUT_PROFILE_SELECT) begin
        next_regRdData = {2'h0, selField};
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_MULT_LO) begin
        next_regRdData = profA.freqMult[7:0];
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_MULT_HI) begin
        next_regRdData = {2'h0, profA.freqMult[13:8]};
      end else if (regAddr == `ADDR_PROFILE_A_PERIOD_LOW_BOUND) begin
        next_regRdData = profA.periodLow;
      end else if (regAddr == `ADDR_PROFILE_A_PERIOD_HIGH_BOUND) begin
        next_regRdData = profA.periodHigh;
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_LOW_BOUND_LO) begin
        next_regRdData = profA.freqLow[7:0];
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_LOW_BOUND_HI) begin
        next_regRdData = profA.freqLow[15:8];
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_HIGH_BOUND_LO) begin
        next_regRdData = profA.freqHigh[7:0];
      end else if (regAddr == `ADDR_PROFILE_A_FREQ_HIGH_BOUND_HI) begin
        next_regRdData = profA.freqHigh[15:8];
      end else if (regAddr == `ADDR_PROFILE_A_WINDOW_CYCLES) begin
        next_regRdData = profA.windowCycles;
      end else if (regAddr == `ADDR_PROFILE_A_PRESCALE) begin
        next_regRdData = {7'h00, profA.prescale};
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_MULT_LO) begin
        next_regRdData = profB.freqMult[7:0];
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_MULT_HI) begin
        next_regRdData = {2'h0, profB.freqMult[13:8]};
      end else if (regAddr == `ADDR_PROFILE_B_PERIOD_LOW_BOUND) begin
        next_regRdData = profB.periodLow;
      end else if (regAddr == `ADDR_PROFILE_B_PERIOD_HIGH_BOUND) begin
        next_regRdData = profB.periodHigh;
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_LOW_BOUND_LO) begin
        next_regRdData = profB.freqLow[7:0];
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_LOW_BOUND_HI) begin
        next_regRdData = profB.freqLow[15:8];
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_HIGH_BOUND_LO) begin
        next_regRdData = profB.freqHigh[7:0];
      end else if (regAddr == `ADDR_PROFILE_B_FREQ_HIGH_BOUND_HI) begin
        next_regRdData = profB.freqHigh[15:8];
      end else if (regAddr == `ADDR_PROFILE_B_WINDOW_CYCLES) begin
        next_regRdData = profB.windowCycles;
      end else if (regAddr == `ADDR_PROFILE_B_PRESCALE) begin
        next_regRdData = {7'h00, profB.prescale};
      end else begin
        next_regRdData = `REG_RESET; // unmapped reads as zero
      end
    end
  end

  // per-input limit checks; a verdict moves when a result arrives and clears in auto or reserved mode
  always_comb begin
    profile_t prof;
    logic [1:0] sel;
    prof = profA;
    sel = 2'h0;
    next_periodFail = periodFail;
    next_freqFail = freqFail;
    for (int i = 0; i < 3; i++) begin
      sel = selField[2*i +: 2];
      prof = pickProfile(sel, profA, profB);
      // auto detect and reserved leave the custom checks idle
      if (sel != SEL_PROFILE_A && sel != SEL_PROFILE_B) begin
        next_periodFail[i] = 1'b0;
        next_freqFail[i] = 1'b0;
      end else begin
        if (periodValid[i]) begin
          next_periodFail[i] = outOfRange({8'h00, periodMeas[i]},
            {8'h00, prof.periodLow}, {8'h00, prof.periodHigh});
        end
        if (freqValid[i]) begin
          next_freqFail[i] = outOfRange(freqMeas[i], prof.freqLow,
            prof.freqHigh);
        end
      end
    end
  end

  // configuration for the monitor datapath, built from the next state so
  // the registered outputs follow a write by one cycle, as the bank does
  always_comb begin
    profile_t prof;
    prof = next_profA;
    for (int i = 0; i < 3; i++) begin
      prof = pickProfile(next_selField[2*i +: 2], next_profA, next_profB);
      next_inputProfileSelect[i] = next_selField[2*i +: 2];
      // window is programmed minus one, so add it back here
      next_cfmWindowLen[i] = {1'b0, prof.windowCycles} + 9'h001;
      next_cfmPrescale[i] = prof.prescale;
      next_nominalMult[i] = prof.freqMult;
    end
  end

  // all state registers; everything but cfmWindowLen clears to zero on reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      profA <= '0;
      profB <= '0;
      selField <= 6'h00;
      regRdData <= `REG_RESET;
      periodFail <= 3'h0;
      freqFail <= 3'h0;
      inputProfileSelect <= 6'h00;
      cfmPrescale <= 3'h0;
      cfmWindowLen <= {3{9'h001}}; // zero field means one cycle
      nominalMult <= '0;
    end else begin
      profA <= next_profA;
      profB <= next_profB;
      selField <= next_selField;
      regRdData <= next_regRdData;
      periodFail <= next_periodFail;
      freqFail <= next_freqFail;
      inputProfileSelect <= next_inputProfileSelect;
      cfmPrescale <= next_cfmPrescale;
      cfmWindowLen <= next_cfmWindowLen;
      nominalMult <= next_nominalMult;
    end
  end

endmodule : custom_ref_monitor_config

// ==== testbench/custom_ref_monitor_config_sva.sv ====
// assertion checker for the custom reference profile bank
`timescale 1ns/1ps
module custom_ref_monitor_config_chk (
  input wire logic core_clk, // clock
  input wire logic rst, // sync reset
  input wire logic [6:0] regAddr, // address
  input wire logic [7:0] regWrData, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  input wire logic [7:0] regRdData, // read data
  input wire logic [2:0] freqValid, // freq strobe
  input wire logic [2:0][1:0] inputProfileSelect, // modes
  input wire logic [2:0] cfmPrescale, // prescale
  input wire logic [2:0][8:0] cfmWindowLen, // window length
  input wire logic [2:0][13:0] nominalMult, // nominal mult
  input wire logic [2:0] periodFail, // period fail
  input wire logic [2:0] freqFail // freq fail
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // write then read of one register on the next cycle
  sequence wrLow; regWr && regAddr == 7'h69; endsequence
  sequence rdLow; regRd && !regWr && regAddr == 7'h69; endsequence
  AST_RESET_CLEAR: assert property (disable iff (1'b0) rst |=>
    regRdData == 8'h00 && freqFail == 3'h0 && periodFail == 3'h0)
    else $error("outputs not cleared by reset");
  AST_UNMAPPED: assert property (regRd && (regAddr < 7'h65 ||
    regAddr == 7'h66 || regAddr > 7'h7A) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!regRd |=> $stable(regRdData))
    else $error("read data moved without a read");
  AST_READ_BACK: assert property (wrLow ##1 rdLow |=>
    regRdData == $past(regWrData, 2))
    else $error("read back differs from write");
  AST_WINDOW: assert property (regWr && regAddr == 7'h6F &&
    inputProfileSelect[0] == 2'h1 |=>
    cfmWindowLen[0] == {1'b0, $past(regWrData)} + 9'h001)
    else $error("window length not field plus one");
  AST_PRESCALE: assert property (regWr && regAddr == 7'h70 &&
    inputProfileSelect[0] == 2'h1 |=> cfmPrescale[0] == $past(regWrData[0]))
    else $error("prescale not taken from bit 0");
  AST_MULT_B: assert property (regWr && regAddr == 7'h71 &&
    inputProfileSelect[1] == 2'h2 |=> nominalMult[1][7:0] == $past(regWrData))
    else $error("profile B mult low byte wrong");
  AST_AUTO_NOFAIL: assert property (inputProfileSelect[2] == 2'h0 |=>
    !freqFail[2] && !periodFail[2])
    else $error("fail raised in auto mode");
  AST_RSVD_NOFAIL: assert property (inputProfileSelect[0] == 2'h3 |=>
    !freqFail[0] && !periodFail[0])
    else $error("fail raised in reserved mode");
  AST_FAIL_STANDS: assert property (!freqValid[0] &&
    inputProfileSelect[0] == 2'h1 |=> $stable(freqFail[0]))
    else $error("freq fail moved without a strobe");
endmodule : custom_ref_monitor_config_chk

bind custom_ref_monitor_config custom_ref_monitor_config_chk chk (.core_clk,
  .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .freqValid,
  .inputProfileSelect, .cfmPrescale, .cfmWindowLen, .nominalMult,
  .periodFail, .freqFail);

// ==== testbench/custom_ref_monitor_config_tb.sv ====
// self-checking bench for the custom reference profile bank
`timescale 1ns/1ps
module custom_ref_monitor_config_tb;
  logic core_clk = 1'b0;
  logic rst, regWr, regRd;
  logic [6:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [2:0] periodValid, freqValid, cfmPrescale, periodFail, freqFail;
  logic [2:0][7:0] periodMeas;
  logic [2:0][15:0] freqMeas;
  logic [2:0][1:0] inputProfileSelect;
  logic [2:0][8:0] cfmWindowLen;
  logic [2:0][13:0] nominalMult;
  int failures = 0;
  int total_checks = 0;
  // rows: address, write data, expected read back (reserved bits drop);
  // profile A prescale set as for a fast reference, profile B left clear
  logic [23:0] rows [23] = '{24'h65D919, 24'h673434, 24'h68FF3F,
    24'h691010, 24'h6A2020, 24'h6B3434, 24'h6C1212, 24'h6D4040,
    24'h6E1212, 24'h6FFFFF, 24'h70FF01, 24'h71ABAB, 24'h72C505,
    24'h730505, 24'h74F0F0, 24'h750000, 24'h760101, 24'h77FFFF,
    24'h780101, 24'h790707, 24'h7AFE00, 24'h665A00, 24'h7B7700};

  // 100 MHz system clock
  always #5 core_clk = ~core_clk;

  custom_ref_monitor_config dut (.core_clk, .rst, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .periodValid, .periodMeas, .freqValid,
    .freqMeas, .inputProfileSelect, .cfmPrescale, .cfmWindowLen,
    .nominalMult, .periodFail, .freqFail);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one register port cycle, driven on the edge by non-blocking update
  task automatic cyc(input logic w, r, input logic [6:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWrData <= d;
  endtask : cyc

  // read data lands the cycle after the read edge
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b0, a, 8'h00);
    #1 chk(regRdData, e);
  endtask : rd

  // one monitor strobe, fail flag checked a cycle later
  task automatic mon(input int i, input bit f, input logic [15:0] m,
                     input logic e);
    @(posedge core_clk);
    if (f) begin
      freqValid[i] <= 1'b1;
      freqMeas[i] <= m;
    end else begin
      periodValid[i] <= 1'b1;
      periodMeas[i] <= m[7:0];
    end
    @(posedge core_clk);
    freqValid <= 3'h0;
    periodValid <= 3'h0;
    #1 chk(f ? freqFail[i] : periodFail[i], e);
  endtask : mon

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    {rst, regWr, regRd, regAddr, regWrData} <= {1'b1, 17'h0};
    {periodValid, freqValid, periodMeas, freqMeas} <= '0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[k]) cyc(1'b1, 1'b0, rows[k][22:16], rows[k][15:8]);
    foreach (rows[k]) rd(rows[k][22:16], rows[k][7:0]);
    $display("test table done");
    chk(nominalMult[0], 16'h3F34);
    chk(cfmWindowLen[0], 16'h0100);
    chk(cfmPrescale, 16'h0005);
    chk(nominalMult[1], 16'h05AB);
    chk(cfmWindowLen[1], 16'h0008);
    chk(inputProfileSelect, 16'h0019);
    $display("test outputs done");
    // bounds pass inclusive, one step outside fails
    mon(0, 1'b1, 16'h1233, 1'b1);
    mon(0, 1'b1, 16'h1234, 1'b0);
    mon(0, 1'b1, 16'h1240, 1'b0);
    mon(0, 1'b1, 16'h1241, 1'b1);
    mon(0, 1'b0, 16'h000F, 1'b1);
    mon(0, 1'b0, 16'h0020, 1'b0);
    mon(1, 1'b0, 16'h00F1, 1'b1);
    mon(1, 1'b0, 16'h0005, 1'b0);
    mon(1, 1'b1, 16'h01FF, 1'b0);
    mon(1, 1'b1, 16'h00FF, 1'b1);
    $display("test limits done");
    // same-cycle write and read returns the old value
    cyc(1'b1, 1'b1, 7'h69, 8'h77);
    cyc(1'b0, 1'b1, 7'h69, 8'h00);
    #1 chk(regRdData, 8'h10);
    cyc(1'b0, 1'b0, 7'h69, 8'h00);
    #1 chk(regRdData, 8'h77);
    $display("test collision done");
    // reserved mode on input 0 clears its verdict and ignores strobes
    cyc(1'b1, 1'b0, 7'h65, 8'h1B);
    cyc(1'b0, 1'b0, 7'h65, 8'h00);
    #1 chk(inputProfileSelect, 16'h001B);
    mon(0, 1'b1, 16'h0000, 1'b0);
    $display("test reserved mode done");
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[k]) rd(rows[k][22:16], 8'h00);
    chk(cfmWindowLen[0], 16'h0001);
    chk({freqFail, periodFail}, 16'h0000);
    $display("test reset done");
    wrap_up;
  end

  // watchdog: the run needs a few hundred cycles at most
  initial begin
    #20000;
    failures++;
    wrap_up;
  end
endmodule : custom_ref_monitor_config_tb
